// >>> shared/dio_defs.svh
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

// ==========================================================
// Register byte offsets
`define OFF_STATUS 8'h00
`define OFF_CLEAR 8'h04
`define OFF_MASK 8'h08
`define OFF_IN_LO 8'h0c
`define OFF_IN_HI 8'h10
`define OFF_OUT_LO 8'h14
`define OFF_OUT_HI 8'h18
`define OFF_MODE8 8'h1c
`define OFF_MODE32 8'h20
`define OFF_PWM_SEL 8'h24
`define OFF_PWM_TIME 8'h28
`define OFF_REV 8'h2c

// ==========================================================
// Status bit positions and reset value
`define ST_RST 0
`define ST_CERR 1
`define ST_STRM 2
`define ST_W 3
`define STATUS_RESET 3'h1
`define CLEAR_BIT 0

// ==========================================================
// Timing
`define CLK_MHZ 200
`define SAMPLE_MS 2
`define DEBOUNCE_MS 10
`define SAMPLE_CYCLES (`SAMPLE_MS * `CLK_MHZ * 1000)
`define DEB_TICKS (`DEBOUNCE_MS / `SAMPLE_MS)

// ==========================================================
// Sizes and firmware revision gate
`define NUM_CH 48
`define PWM_CH_FULL 32
`define PWM_CH_OLD 8
`define FW_REV_DEFAULT 16'h0102
`define FW_REV_32CH 16'h0102

`endif

// >>> shared/dio_pkg.sv
package dio_pkg;
   typedef logic [7:0] reg_addr_t;
   typedef logic [31:0] reg_data_t;
   typedef logic [4:0] pwm_ch_t;
   typedef struct packed {
      logic [7:0] off_time;
      logic [7:0] on_time;
   } pwm_time_t;
   typedef enum logic [1:0] {
      DEB_WAIT = 2'b01,
      DEB_RUN = 2'b10
   } deb_state_t;
endpackage

// >>> shared/pwm_mem_if.sv
`timescale 1ns/100ps
interface pwm_mem_if;
   import dio_pkg::*;
   logic we;
   pwm_ch_t waddr;
   pwm_time_t wdata;
   pwm_ch_t raddr;
   pwm_time_t rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> src/pwm_time_mem.sv
`timescale 1ns/100ps
module pwm_time_mem #(
   parameter int DEPTH = 32
) (
   input wire logic i_clk_sys, // System clock
   input wire logic i_rst,     // Async reset, high
   pwm_mem_if.mem bus          // Memory port
);
   import dio_pkg::*;

   pwm_time_t store [DEPTH];

   // ==========================================================
   // Storage, no reset so it can map to RAM
   always_ff @(posedge i_clk_sys) begin
      if (bus.we) begin
         store[bus.waddr] <= bus.wdata;
      end
   end

   // ==========================================================
   // Registered read
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         bus.rdata <= '0;
      end else begin
         bus.rdata <= store[bus.raddr];
      end
   end
endmodule

// >>> src/dio_port.sv
// Behaviour
// - A detected fault in the output serial stream sets a sticky stream fault flag.
// - The stream fault flag holds until the clear flags action, which drops it; here a status write with bit 2 set drops it too.
// - The status word carries the stream fault flag beside the reset and comm error flags.
// - Input reads give 48 channel states, channel 0 in the lsb of byte 0, byte by byte upward.
// - Inputs are sampled each 2 ms tick and reported only after 10 ms of stability; here the first tick after reset reports its sample at once.
// - Input reads show the debounced pin level of every channel whatever its mode.
// - The eight channel mode read gives bit n as the mode of channel n, 1 for PWM.
// - The 32 channel mode read gives channel n at bit n mod 8 of byte n div 8.
// - The 32 channel mode map exists only from revision 1.02; before that only eight PWM channels; here older revisions decode it for channels 0 to 7.
// - Output reads give the 48 programmed driver states packed like the inputs.
// - Output read bits of PWM channels are undefined and must not be relied on.
// - Each PWM channel holds a readable 8 bit on time and 8 bit off time in 2 ms units.
//
// Chosen here: the register addresses and the strobed register port.
`include "dio_defs.svh"
`timescale 1ns/100ps
module dio_port #(
   parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
   parameter logic [15:0] FW_REV = `FW_REV_DEFAULT
) (
   input wire logic i_clk_sys,                // System clock, 200 MHz
   input wire logic i_rst,                    // Async reset, high
   input wire dio_pkg::reg_addr_t i_addr,     // Register byte address
   input wire dio_pkg::reg_data_t i_wr_data,  // Write data
   input wire logic i_wr,                     // Write strobe
   input wire logic i_rd,                     // Read strobe
   output dio_pkg::reg_data_t o_rd_data,      // Read data, cycle after strobe
   input wire logic [`NUM_CH-1:0] i_pins,     // Channel pin levels
   input wire logic i_stream_fault,           // Serial driver stream fault
   input wire logic i_comm_error,             // Comm error pulse
   output logic [`NUM_CH-1:0] o_drive,        // Programmed driver states
   output logic [`PWM_CH_FULL-1:0] o_pwm_en,  // Per channel PWM mode
   output logic o_irq                         // Interrupt, high level
);
   import dio_pkg::*;

   localparam logic MODES32_OK = (FW_REV >= `FW_REV_32CH);
   localparam int PWM_CH = MODES32_OK ? `PWM_CH_FULL : `PWM_CH_OLD;
   localparam int TICK_W = $clog2(SAMPLE_CYCLES);
   localparam logic [2:0] DEB_TICKS = 3'(`DEB_TICKS);

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   logic [`NUM_CH-1:0] sync1;
   logic [`NUM_CH-1:0] sync2;
   logic [`NUM_CH-1:0] sync3;
   logic [`NUM_CH-1:0] agreed;
   logic [`NUM_CH-1:0] last;
   logic [`NUM_CH-1:0] deb;
   logic [2:0] cnt [`NUM_CH];
   logic [TICK_W-1:0] tick_cnt;
   logic tick;
   deb_state_t deb_state;
   logic flt1;
   logic flt2;
   logic flt3;
   logic flt_agreed;
   logic flt_prev;
   logic fault_evt;
   logic [`ST_W-1:0] status;
   logic [`ST_W-1:0] mask;
   logic [`ST_W-1:0] clr_bits;
   logic clear_act;
   pwm_ch_t pwm_sel;
   logic wr_hit;
   pwm_mem_if pm ();

   function automatic logic hit(input reg_addr_t a, input reg_addr_t off);
      return a == off;
   endfunction

   // ==========================================================
   // Input synchroniser: a change counts once stages 2 and 3 agree
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         agreed <= '0;
      end else begin
         sync1 <= i_pins;
         sync2 <= sync1;
         sync3 <= sync2;
         agreed <= (sync3 & ~(sync2 ^ sync3)) | (agreed & (sync2 ^ sync3));
      end
   end

   // ==========================================================
   // Sample tick
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else if (tick_cnt == TICK_W'(SAMPLE_CYCLES - 1)) begin
         tick_cnt <= '0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
         tick <= 1'b0;
      end
   end

   // ==========================================================
   // Debounce, all channels alike regardless of mode
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         deb_state <= DEB_WAIT;
         last <= '0;
         deb <= '0;
         for (int i = 0; i < `NUM_CH; i++) begin
            cnt[i] <= '0;
         end
      end else if (tick) begin
         unique case (deb_state)
            DEB_WAIT: begin
               // First sample seeds the history, no waiting for it
               last <= agreed;
               deb <= agreed;
               deb_state <= DEB_RUN;
            end
            DEB_RUN: begin
               for (int i = 0; i < `NUM_CH; i++) begin
                  if (agreed[i] != last[i]) begin
                     last[i] <= agreed[i];
                     cnt[i] <= '0;
                  end else if (cnt[i] != DEB_TICKS) begin
                     cnt[i] <= cnt[i] + 3'h1;
                     // Six equal samples span the full 10 ms
                     if (cnt[i] == DEB_TICKS - 3'h1) begin
                        deb[i] <= last[i];
                     end
                  end
               end
            end
         endcase
      end
   end

   deb_on_tick_a: assert property (!$stable(deb) |-> $past(tick))
      else $error("Debounced state moved off a tick");
   // Checked on channel 0 only; all channels share the same loop body
   deb_stable_a: assert property (tick && deb_state == DEB_RUN && agreed[0] != last[0] |=>
      ##1 deb[0] == $past(deb[0], 2))
      else $error("Debounced bit followed a fresh change");
   first_sample_a: assert property (tick && deb_state == DEB_WAIT |=>
      deb == $past(agreed) && deb_state == DEB_RUN)
      else $error("History not seeded from first sample");

   // ==========================================================
   // Stream fault event, same three stage rule as the pins
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         flt1 <= 1'b0;
         flt2 <= 1'b0;
         flt3 <= 1'b0;
         flt_agreed <= 1'b0;
         flt_prev <= 1'b0;
      end else begin
         flt1 <= i_stream_fault;
         flt2 <= flt1;
         flt3 <= flt2;
         if (flt2 == flt3) begin
            flt_agreed <= flt3;
         end
         flt_prev <= flt_agreed;
      end
   end

   assign fault_evt = flt_agreed & ~flt_prev;
   assign wr_hit = i_wr;
   assign clear_act = wr_hit && hit(i_addr, `OFF_CLEAR) && i_wr_data[`CLEAR_BIT];
   assign clr_bits = clear_act ? {`ST_W{1'b1}} :
                     (wr_hit && hit(i_addr, `OFF_STATUS)) ? i_wr_data[`ST_W-1:0] : '0;

   // ==========================================================
   // Sticky status; a set in the clearing cycle wins
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         status <= `STATUS_RESET;
      end else begin
         status[`ST_RST] <= status[`ST_RST] & ~clr_bits[`ST_RST];
         status[`ST_CERR] <= i_comm_error | (status[`ST_CERR] & ~clr_bits[`ST_CERR]);
         status[`ST_STRM] <= fault_evt | (status[`ST_STRM] & ~clr_bits[`ST_STRM]);
      end
   end

   fault_sets_a: assert property (fault_evt |=> status[`ST_STRM])
      else $error("Stream fault did not set its flag");
   fault_holds_a: assert property (status[`ST_STRM] && !clr_bits[`ST_STRM] |=> status[`ST_STRM])
      else $error("Stream fault flag dropped without clear");
   fault_clears_a: assert property (clear_act && !fault_evt |=> !status[`ST_STRM])
      else $error("Clear action left stream fault set");
   clear_all_a: assert property (clear_act && !i_comm_error && !fault_evt |=> status == '0)
      else $error("Clear action left a flag set");
   cerr_sets_a: assert property (i_comm_error |=> status[`ST_CERR])
      else $error("Comm error did not set its flag");
   // Only reset raises this flag, so nothing in the clock domain may set it
   rst_flag_a: assert property (!status[`ST_RST] |=> !status[`ST_RST])
      else $error("Reset flag rose outside reset");

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         mask <= '0;
      end else if (wr_hit && hit(i_addr, `OFF_MASK)) begin
         mask <= i_wr_data[`ST_W-1:0];
      end
   end

   mask_write_a: assert property (i_wr && i_addr == `OFF_MASK |=> mask == $past(i_wr_data[`ST_W-1:0]))
      else $error("Mask not taken from write");

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(status & mask);
      end
   end

   irq_follows_a: assert property (##1 o_irq == $past(|(status & mask)))
      else $error("Interrupt does not track masked status");

   // ==========================================================
   // Programmed driver states
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_drive <= '0;
      end else if (wr_hit && hit(i_addr, `OFF_OUT_LO)) begin
         o_drive[31:0] <= i_wr_data;
      end else if (wr_hit && hit(i_addr, `OFF_OUT_HI)) begin
         o_drive[`NUM_CH-1:32] <= i_wr_data[`NUM_CH-33:0];
      end
   end

   // Upper word is watched through the read path
   drive_write_a: assert property (i_wr && i_addr == `OFF_OUT_LO |=> o_drive[31:0] == $past(i_wr_data))
      else $error("Driver states not taken from write");

   // ==========================================================
   // Mode map; older revisions keep the upper channels standard
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_pwm_en <= '0;
      end else if (wr_hit && hit(i_addr, `OFF_MODE8)) begin
         o_pwm_en[`PWM_CH_OLD-1:0] <= i_wr_data[`PWM_CH_OLD-1:0];
      end else if (wr_hit && hit(i_addr, `OFF_MODE32)) begin
         if (MODES32_OK) begin
            o_pwm_en <= i_wr_data;
         end else begin
            o_pwm_en[`PWM_CH_OLD-1:0] <= i_wr_data[`PWM_CH_OLD-1:0];
         end
      end
   end

   old_rev_a: assert property (!MODES32_OK |-> o_pwm_en[`PWM_CH_FULL-1:`PWM_CH_OLD] == '0)
      else $error("Upper PWM modes set on old revision");
   mode8_write_a: assert property (i_wr && i_addr == `OFF_MODE8 |=>
      o_pwm_en[7:0] == $past(i_wr_data[7:0]))
      else $error("Eight channel modes not taken from write");

   // ==========================================================
   // PWM time table, one selected channel at a time
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         pwm_sel <= '0;
      end else if (wr_hit && hit(i_addr, `OFF_PWM_SEL)) begin
         // Channels past the supported count wrap into range
         pwm_sel <= i_wr_data[4:0] & pwm_ch_t'(PWM_CH - 1);
      end
   end

   assign pm.we = wr_hit && hit(i_addr, `OFF_PWM_TIME);
   assign pm.waddr = pwm_sel;
   assign pm.wdata = i_wr_data[15:0];
   assign pm.raddr = pwm_sel;

   pwm_time_mem #(
      .DEPTH(`PWM_CH_FULL)
   ) u_pwm_mem (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .bus(pm.mem)
   );

   sel_range_a: assert property (int'(pwm_sel) < PWM_CH)
      else $error("PWM select beyond supported channels");

   // ==========================================================
   // Read port, data stands only in the cycle after the strobe
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= '0;
      end else if (i_rd) begin
         unique case (i_addr)
            `OFF_STATUS: o_rd_data <= 32'(status);
            `OFF_MASK: o_rd_data <= 32'(mask);
            `OFF_IN_LO: o_rd_data <= deb[31:0];
            `OFF_IN_HI: o_rd_data <= 32'(deb[`NUM_CH-1:32]);
            // PWM channels return the stored value, not the live level
            `OFF_OUT_LO: o_rd_data <= o_drive[31:0];
            `OFF_OUT_HI: o_rd_data <= 32'(o_drive[`NUM_CH-1:32]);
            `OFF_MODE8: o_rd_data <= 32'(o_pwm_en[`PWM_CH_OLD-1:0]);
            `OFF_MODE32: o_rd_data <= o_pwm_en;
            `OFF_PWM_SEL: o_rd_data <= 32'(pwm_sel);
            `OFF_PWM_TIME: o_rd_data <= 32'(pm.rdata);
            `OFF_REV: o_rd_data <= 32'(FW_REV);
            default: o_rd_data <= '0;
         endcase
      end else begin
         o_rd_data <= '0;
      end
   end

   status_read_a: assert property (i_rd && i_addr == `OFF_STATUS |=> o_rd_data == 32'($past(status)))
      else $error("Status read wrong");
   input_read_a: assert property (i_rd && i_addr == `OFF_IN_LO |=> o_rd_data == $past(deb[31:0]))
      else $error("Input low read wrong");
   input_hi_read_a: assert property (i_rd && i_addr == `OFF_IN_HI |=>
      o_rd_data == 32'($past(deb[47:32])))
      else $error("Input high read wrong");
   mode8_read_a: assert property (i_rd && i_addr == `OFF_MODE8 |=>
      o_rd_data[31:8] == '0 && o_rd_data[7:0] == $past(o_pwm_en[7:0]))
      else $error("Eight channel mode read wrong");
   mode32_read_a: assert property (i_rd && i_addr == `OFF_MODE32 |=> o_rd_data == $past(o_pwm_en))
      else $error("32 channel mode read wrong");
   output_read_a: assert property (i_rd && i_addr == `OFF_OUT_HI |=>
      o_rd_data == 32'($past(o_drive[47:32])))
      else $error("Output high read wrong");
   time_read_a: assert property (i_rd && i_addr == `OFF_PWM_TIME |=>
      o_rd_data == 32'($past(pm.rdata)))
      else $error("PWM time read wrong");
   idle_read_a: assert property (!i_rd |=> o_rd_data == '0)
      else $error("Read data outside its cycle");

   fault_seen_c: cover property (fault_evt ##[1:20] clear_act);
   debounce_seen_c: cover property (tick && deb_state == DEB_RUN ##1 !$stable(deb));
   pwm_mode_c: cover property (wr_hit && hit(i_addr, `OFF_MODE32) ##1 o_pwm_en[31]);
   irq_seen_c: cover property ($rose(o_irq));
   reseed_c: cover property (tick && deb_state == DEB_WAIT);
endmodule

// >>> test/ctrl_model.sv
`include "dio_defs.svh"
`timescale 1ns/100ps
// ==========================================================
// Controller side of the register port
module ctrl_model (
   input wire logic i_clk_sys,              // System clock
   input wire dio_pkg::reg_data_t i_rd_data, // Read data from the port
   output dio_pkg::reg_addr_t o_addr,        // Register address
   output dio_pkg::reg_data_t o_wr_data,     // Write data
   output logic o_wr,                        // Write strobe
   output logic o_rd                         // Read strobe
);
   import dio_pkg::*;
   initial begin
      o_addr = 8'h00;
      o_wr_data = 32'h0;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // One strobe per call, then one idle cycle, so no strobe is set twice at one edge
   task automatic write_reg(input reg_addr_t a, input reg_data_t d);
      @(posedge i_clk_sys);
      o_addr <= a;
      o_wr_data <= d;
      o_wr <= 1'b1;
      @(posedge i_clk_sys);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wr_data <= ~d;
      // Step past the edge so callers see the written state
      #1;
   endtask
   // Answer stands only in the cycle after the strobe
   task automatic read_reg(input reg_addr_t a, output reg_data_t d);
      @(posedge i_clk_sys);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk_sys);
      o_rd <= 1'b0;
      o_addr <= ~a;
      #1;
      d = i_rd_data;
   endtask
   task automatic set_modes(input logic [31:0] m);
      write_reg(`OFF_MODE32, m);
   endtask
   task automatic clear_flags();
      write_reg(`OFF_CLEAR, 32'h1);
   endtask
endmodule

// >>> test/test_debounced_dio_port_with_pwm_modes.sv
`include "dio_defs.svh"
`timescale 1ns/100ps
module test_debounced_dio_port_with_pwm_modes;
   import dio_pkg::*;
   // Short tick keeps the 10 ms debounce at about 100 cycles
   localparam int SC = 20;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic [47:0] pins = 48'h0;
   logic stream_fault = 1'b0;
   logic comm_error = 1'b0;
   reg_addr_t addr;
   reg_data_t wdata;
   logic wr;
   logic rd;
   reg_data_t rd_data;
   reg_data_t old_rd_data;
   logic [47:0] drive;
   logic [31:0] pwm_en;
   logic [31:0] old_pwm_en;
   logic irq;
   int fails = 0;
   int samples_checked = 0;
   int seed = 32'h07a6;
   // ==========================================================
   // Reference model state
   logic [31:0] exp_mode;
   logic [47:0] exp_in;
   logic [15:0] exp_time[$];
   int ch_list[3] = '{0, 7, 31};
   logic [31:0] mode_tab[4];
   reg_data_t got;
   logic [47:0] val;
   logic [15:0] t;
   always #2.5 i_clk_sys = ~i_clk_sys;
   ctrl_model ctrl_model_i (.i_clk_sys(i_clk_sys), .i_rd_data(rd_data), .o_addr(addr), .o_wr_data(wdata),
      .o_wr(wr), .o_rd(rd));
   dio_port #(.SAMPLE_CYCLES(SC), .FW_REV(16'h0102)) dio_port_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data), .i_pins(pins),
      .i_stream_fault(stream_fault), .i_comm_error(comm_error), .o_drive(drive), .o_pwm_en(pwm_en), .o_irq(irq));
   // Older firmware: only eight PWM channels
   dio_port #(.SAMPLE_CYCLES(SC), .FW_REV(16'h0101)) dio_port_old_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(old_rd_data), .i_pins(pins),
      .i_stream_fault(stream_fault), .i_comm_error(comm_error), .o_drive(), .o_pwm_en(old_pwm_en), .o_irq());
   // ==========================================================
   // Compare and helper tasks
   task automatic check_read(input reg_data_t g, input reg_data_t e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t read %h expected %h", $time, g, e);
      end
   endtask
   task automatic check_port(input logic [47:0] g, input logic [47:0] e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t port %h expected %h", $time, g, e);
      end
   endtask
   task automatic rd_chk(input reg_addr_t a, input reg_data_t e);
      ctrl_model_i.read_reg(a, got);
      check_read(got, e);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic set_pins(input logic [47:0] v);
      @(posedge i_clk_sys);
      pins <= v;
   endtask
   task automatic chk_in(input logic [47:0] e);
      rd_chk(`OFF_IN_LO, e[31:0]);
      rd_chk(`OFF_IN_HI, {16'h0, e[47:32]});
   endtask
   task automatic give_verdict();
      $display("checked %0d failed %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      fails++;
      give_verdict();
   end
   // ==========================================================
   // Main sequence
   initial begin
      mode_tab = '{$random(seed), 32'hffffffff, 32'h0, $random(seed)};
      repeat (4) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rd_chk(`OFF_STATUS, `STATUS_RESET);
      rd_chk(`OFF_MODE32, 32'h0);
      rd_chk(`OFF_IN_LO, 32'h0);
      foreach (mode_tab[k]) begin
         exp_mode = mode_tab[k];
         ctrl_model_i.set_modes(exp_mode);
         rd_chk(`OFF_MODE32, exp_mode);
         check_read(old_rd_data, {24'h0, exp_mode[7:0]});
         rd_chk(`OFF_MODE8, {24'h0, exp_mode[7:0]});
         check_port({16'h0, pwm_en}, {16'h0, exp_mode});
         check_port({16'h0, old_pwm_en}, {40'h0, exp_mode[7:0]});
      end
      ctrl_model_i.write_reg(`OFF_MODE8, 32'h5a);
      exp_mode[7:0] = 8'h5a;
      rd_chk(`OFF_MODE32, exp_mode);
      val = {16'($random(seed)), 32'($random(seed))};
      ctrl_model_i.write_reg(`OFF_OUT_LO, val[31:0]);
      ctrl_model_i.write_reg(`OFF_OUT_HI, {16'h0, val[47:32]});
      check_port(drive, val);
      ctrl_model_i.read_reg(`OFF_OUT_LO, got);
      check_read(got & ~exp_mode, val[31:0] & ~exp_mode);
      rd_chk(`OFF_OUT_HI, {16'h0, val[47:32]});
      ctrl_model_i.write_reg(8'h30, 32'hffffffff);
      rd_chk(8'h30, 32'h0);
      foreach (ch_list[k]) begin
         t = 16'($random(seed));
         exp_time.push_back(t);
         ctrl_model_i.write_reg(`OFF_PWM_SEL, ch_list[k]);
         ctrl_model_i.write_reg(`OFF_PWM_TIME, {16'h0, t});
      end
      foreach (ch_list[k]) begin
         ctrl_model_i.write_reg(`OFF_PWM_SEL, ch_list[k]);
         rd_chk(`OFF_PWM_TIME, {16'h0, exp_time.pop_front()});
      end
      rd_chk(`OFF_PWM_SEL, 32'h1f);
      check_read(old_rd_data, 32'h7);
      // Inputs read while every mapped channel is in PWM mode
      ctrl_model_i.set_modes(32'hffffffff);
      ctrl_model_i.write_reg(`OFF_IN_LO, 32'hffffffff);
      exp_in = {16'($random(seed)), 32'($random(seed))};
      set_pins(exp_in);
      wait_cyc(140);
      chk_in(exp_in);
      set_pins(~exp_in);
      wait_cyc(60);
      chk_in(exp_in);
      wait_cyc(100);
      exp_in = ~exp_in;
      chk_in(exp_in);
      set_pins(48'h0);
      wait_cyc(40);
      set_pins(exp_in);
      wait_cyc(160);
      chk_in(exp_in);
      // ==========================================================
      // Sticky flags and interrupt
      ctrl_model_i.write_reg(`OFF_STATUS, 32'h1 << `ST_RST);
      rd_chk(`OFF_STATUS, 32'h0);
      ctrl_model_i.write_reg(`OFF_MASK, 32'h7);
      @(posedge i_clk_sys);
      comm_error <= 1'b1;
      @(posedge i_clk_sys);
      comm_error <= 1'b0;
      wait_cyc(2);
      rd_chk(`OFF_STATUS, 32'h1 << `ST_CERR);
      check_port({47'h0, irq}, 48'h1);
      @(posedge i_clk_sys);
      stream_fault <= 1'b1;
      wait_cyc(12);
      @(posedge i_clk_sys);
      stream_fault <= 1'b0;
      wait_cyc(12);
      rd_chk(`OFF_STATUS, (32'h1 << `ST_CERR) | (32'h1 << `ST_STRM));
      ctrl_model_i.write_reg(`OFF_STATUS, 32'h1 << `ST_CERR);
      rd_chk(`OFF_STATUS, 32'h1 << `ST_STRM);
      ctrl_model_i.write_reg(`OFF_MASK, 32'h1 << `ST_CERR);
      wait_cyc(2);
      check_port({47'h0, irq}, 48'h0);
      ctrl_model_i.write_reg(`OFF_MASK, 32'h1 << `ST_STRM);
      wait_cyc(2);
      check_port({47'h0, irq}, 48'h1);
      ctrl_model_i.clear_flags();
      rd_chk(`OFF_STATUS, 32'h0);
      wait_cyc(2);
      check_port({47'h0, irq}, 48'h0);
      // Mid-run reset with pins held: inputs must show up at the first tick, not after a full debounce
      @(posedge i_clk_sys);
      i_rst <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rd_chk(`OFF_STATUS, `STATUS_RESET);
      rd_chk(`OFF_MODE32, 32'h0);
      wait_cyc(30);
      chk_in(exp_in);
      give_verdict();
   end
endmodule
